// [testbench/csrf_cpu_model.sv]
// Purpose: cpu core stand-in, register port master and interrupt taker
// Assumes: tasks are entered between edges; strobes last one cycle
// Notes:   read data are taken only in the cycle after the strobe
`timescale 1ns/100ps
`include "csrf_regs.svh"
module csrf_cpu_model (
  // clock
  input  wire logic           ref_clk,
  // register port
  output csrf_pkg::csrf_req_s bus_req,
  input  wire logic [7:0]     rd_data_ff,
  // interrupt side
  input  wire logic           css_irq_ff,
  input  wire logic           wake_req_ff,
  output logic                cpu_irq_mask,
  output logic                wait_mode,
  output logic                halt_mode
);
  import csrf_pkg::*;
  int n_irq;
  int n_wake;

  // masked and idle from time zero, as after a core reset
  initial
  begin
    bus_req      = '0;
    cpu_irq_mask = 1'b1;
    wait_mode    = 1'b0;
    halt_mode    = 1'b0;
    n_irq        = 0;
    n_wake       = 0;
  end

  always @(posedge ref_clk)
  begin
    if (css_irq_ff && !cpu_irq_mask)
      n_irq <= n_irq + 1;
    if (wake_req_ff)
      n_wake <= n_wake + 1;
  end

  // mode change lands on the next edge, never mid-request
  task automatic set_mode(input logic m, input logic w, input logic h);
    @(posedge ref_clk);
    cpu_irq_mask <= m;
    wait_mode    <= w;
    halt_mode    <= h;
  endtask

  // one write cycle; strobe dropped after the taking edge
  task automatic bus_write(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus_req <= '0;
  endtask

  // read data stand one cycle only, so sample just after that edge
  task automatic bus_read(input logic [15:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus_req <= '0;
    #1;
    d = rd_data_ff;
  endtask
endmodule

// [testbench/csrf_top_tb.sv]
// Purpose: self-checking bench for the clock security and reset flags
// Assumes: 10 MHz ref_clk; cpu side played by csrf_cpu_model
// Notes:   osc pin made here, half period 0 stops it at its last level
`timescale 1ns/100ps
`include "csrf_regs.svh"
module csrf_top_tb;
  import csrf_pkg::*;
  logic          ref_clk;
  logic          rst;
  csrf_req_s     bus_req;
  logic [7:0]    rd_data_ff;
  logic          css_enable_opt;
  csrf_osc_src_e osc_src_opt;
  logic          osc_in_pin;
  logic          supply_low;
  logic          ext_low;
  wire logic     rst_line_n;
  logic          rst_pin_out_ff;
  logic          rst_pin_oe_ff;
  logic          wdg_underflow;
  logic          cpu_irq_mask;
  logic          wait_mode;
  logic          halt_mode;
  logic          css_irq_ff;
  logic          wake_req_ff;
  logic          backup_sel_ff;
  logic          clk_filtered_ff;
  logic          osc_keep_run_ff;
  logic          osc_enable_ff;
  int            osc_half;
  int            cycles;
  int            n_mismatch;
  int            total_checks;

  // open-drain reset line with pull-up; either party may pull it low
  assign rst_line_n = !(rst_pin_oe_ff && !rst_pin_out_ff) && !ext_low;

  csrf_top u_csrf_top (
    .ref_clk(ref_clk), .rst(rst), .bus_req(bus_req),
    .rd_data_ff(rd_data_ff), .css_enable_opt(css_enable_opt),
    .osc_src_opt(osc_src_opt), .osc_in_pin(osc_in_pin),
    .supply_low(supply_low), .rst_pin_in_n(rst_line_n),
    .rst_pin_out_ff(rst_pin_out_ff), .rst_pin_oe_ff(rst_pin_oe_ff),
    .wdg_underflow(wdg_underflow), .cpu_irq_mask(cpu_irq_mask),
    .wait_mode(wait_mode), .halt_mode(halt_mode),
    .css_irq_ff(css_irq_ff), .wake_req_ff(wake_req_ff),
    .backup_sel_ff(backup_sel_ff), .clk_filtered_ff(clk_filtered_ff),
    .osc_keep_run_ff(osc_keep_run_ff), .osc_enable_ff(osc_enable_ff));

  csrf_cpu_model u_csrf_cpu_model (
    .ref_clk(ref_clk), .bus_req(bus_req), .rd_data_ff(rd_data_ff),
    .css_irq_ff(css_irq_ff), .wake_req_ff(wake_req_ff),
    .cpu_irq_mask(cpu_irq_mask), .wait_mode(wait_mode),
    .halt_mode(halt_mode));

  // main clock
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // main oscillator; toggles fall 1 ns after the sampling edges
  always
  begin
    if (osc_half == 0)
      @(osc_half);
    else
    begin
      #(osc_half);
      osc_in_pin = ~osc_in_pin;
    end
  end

  // a hang still ends in the closing report
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk_byte(input string nm, input logic [7:0] e,
                          input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    total_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] e);
    logic [7:0] d;
    u_csrf_cpu_model.bus_read(`CSRF_STATUS_ADDR, d);
    chk_byte(nm, e, d);
  endtask

  task automatic wr(input logic [7:0] d);
    u_csrf_cpu_model.bus_write(`CSRF_STATUS_ADDR, d);
  endtask

  // options are only captured at the first edge after release
  task automatic do_reset(input logic en, input csrf_osc_src_e src);
    @(posedge ref_clk);
    rst            <= 1'b1;
    css_enable_opt <= en;
    osc_src_opt    <= src;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    step(2);
  endtask

  task automatic t_regs();
    logic [7:0] d;
    chk_bit("osc_enabled", 1'b1, osc_enable_ff);
    rd_chk("status_reset", 8'h00);
    u_csrf_cpu_model.bus_read(16'h002C, d);
    chk_byte("unmapped_read", 8'h00, d);
    u_csrf_cpu_model.bus_write(16'h002C, 8'hFF);
    rd_chk("unmapped_write", 8'h00);
    wr(8'hFF);
    rd_chk("write_ones", 8'h04);
    wr(8'h00);
    rd_chk("write_zero", 8'h00);
  endtask

  task automatic t_watchdog(input logic [7:0] e);
    int n;
    @(posedge ref_clk);
    wdg_underflow <= 1'b1;
    @(posedge ref_clk);
    wdg_underflow <= 1'b0;
    #1;
    chk_bit("pin_drive_wdg", 1'b1, rst_pin_oe_ff);
    chk_bit("pin_low_value", 1'b0, rst_pin_out_ff);
    for (n = 0; n < 400 && rst_pin_oe_ff === 1'b1; n++)
      step(1);
    chk_bit("wdg_pulse_len", 1'b1, n >= 200 && n <= 201);
    rd_chk("flags_wdg", e);
  endtask

  // a watchdog pulse inside the supply drive must not touch the pin
  task automatic t_supply();
    @(posedge ref_clk);
    supply_low <= 1'b1;
    step(4);
    chk_bit("pin_drive_sup", 1'b1, rst_pin_oe_ff);
    @(posedge ref_clk);
    wdg_underflow <= 1'b1;
    @(posedge ref_clk);
    wdg_underflow <= 1'b0;
    step(30);
    chk_bit("pin_held_sup", 1'b1, rst_pin_oe_ff);
    @(posedge ref_clk);
    supply_low <= 1'b0;
    step(6);
    chk_bit("pin_free_sup", 1'b0, rst_pin_oe_ff);
    rd_chk("flags_supply", 8'h11);
    t_watchdog(8'h11);
    @(posedge ref_clk);
    ext_low <= 1'b1;
    repeat (6) @(posedge ref_clk);
    ext_low <= 1'b0;
    step(6);
    rd_chk("flags_ext_pin", 8'h10);
    wr(8'h00);
    rd_chk("flags_cleared", 8'h00);
  endtask

  task automatic t_backup();
    int n;
    do_reset(1'b1, CSRF_SRC_XTAL1);
    u_csrf_cpu_model.set_mode(1'b0, 1'b1, 1'b0);
    wr(8'h04);
    step(20);
    chk_bit("no_backup_good", 1'b0, backup_sel_ff);
    osc_half = 0;
    for (n = 0; n < 80 && backup_sel_ff !== 1'b1; n++)
      step(1);
    chk_bit("backup_taken", 1'b1, backup_sel_ff === 1'b1 && n >= 34);
    step(2);
    chk_bit("irq_raised", 1'b1, css_irq_ff);
    rd_chk("det_set", 8'h06);
    rd_chk("det_held", 8'h06);
    chk_bit("woken", 1'b1, u_csrf_cpu_model.n_wake > 0);
    u_csrf_cpu_model.set_mode(1'b1, 1'b0, 1'b0);
    step(3);
    chk_bit("irq_masked", 1'b0, css_irq_ff);
    u_csrf_cpu_model.set_mode(1'b0, 1'b0, 1'b1);
    wr(8'h00);
    u_csrf_cpu_model.set_mode(1'b0, 1'b0, 1'b0);
    rd_chk("halt_frozen", 8'h06);
    chk_bit("irq_unmasked", 1'b1, css_irq_ff);
    osc_half = 200;
    for (n = 0; n < 80 && backup_sel_ff !== 1'b0; n++)
      step(1);
    chk_bit("main_back", 1'b0, backup_sel_ff);
    rd_chk("det_last", 8'h06);
    rd_chk("det_cleared", 8'h04);
    step(2);
    chk_bit("irq_gone", 1'b0, css_irq_ff);
  endtask

  // fastest pattern the synchroniser can show: a rise every 2 cycles
  task automatic t_filter();
    int n;
    osc_half = 100;
    for (n = 0; n < 100 && clk_filtered_ff !== 1'b1; n++)
      step(1);
    chk_bit("filter_on", 1'b1, clk_filtered_ff);
    osc_half = 200;
    for (n = 0; n < 100 && clk_filtered_ff !== 1'b0; n++)
      step(1);
    chk_bit("filter_off", 1'b0, clk_filtered_ff);
  endtask

  task automatic t_sources();
    for (int s = 0; s < 7; s++)
    begin
      do_reset(1'b1, csrf_osc_src_e'(s));
      step(3);
      chk_bit("keep_run", s >= 1 && s <= 4, osc_keep_run_ff);
    end
  endtask

  task automatic t_disabled();
    do_reset(1'b0, CSRF_SRC_XTAL0);
    osc_half = 0;
    step(80);
    chk_bit("no_backup_off", 1'b0, backup_sel_ff);
    wr(8'h04);
    step(3);
    rd_chk("det_forced_zero", 8'h04);
    chk_bit("irq_off", 1'b0, css_irq_ff);
  endtask

  // main sequence
  initial
  begin
    rst            = 1'b1;
    css_enable_opt = 1'b1;
    osc_src_opt    = CSRF_SRC_XTAL0;
    osc_in_pin     = 1'b0;
    supply_low     = 1'b0;
    ext_low        = 1'b0;
    wdg_underflow  = 1'b0;
    osc_half       = 0;
    cycles         = 0;
    n_mismatch     = 0;
    total_checks   = 0;
    do_reset(1'b1, CSRF_SRC_XTAL0);
    osc_half = 200;
    t_regs();
    t_watchdog(8'h01);
    t_supply();
    t_backup();
    t_filter();
    t_sources();
    t_disabled();
    finish_test();
  end
endmodule

// [verilog/csrf_clk_mon.sv]
// Purpose: main clock filter and backup oscillator selection
// Assumes: osc_level is already synchronised to ref_clk
// Notes:   state holds while frozen, clears when disabled
`timescale 1ns/100ps
module csrf_clk_mon (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // control
  input  wire logic enable,
  input  wire logic freeze,
  input  wire logic osc_level,
  // status
  output logic      backup_ff,
  output logic      filtered_ff
);
  `include "csrf_regs.svh"

  logic [`CSRF_CNT_W-1:0] gap_ff;
  logic [`CSRF_CNT_W-1:0] good_ff;
  logic                   last_ff;
  logic                   edge_seen;
  logic                   too_fast;
  logic                   recovered;

  assign edge_seen = osc_level & ~last_ff;
  assign too_fast  = edge_seen &
                     (gap_ff < `CSRF_CNT_W'(`CSRF_FILTER_CYC - 1));
  assign recovered = edge_seen & ~too_fast &
                     (good_ff >= `CSRF_RECOVER_EDGES - 8'h01);

  // edge spacing and run of good edges
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      // start past the spike limit so a first edge is never too fast
      gap_ff  <= `CSRF_CNT_W'(`CSRF_FILTER_CYC);
      good_ff <= '0;
      last_ff <= 1'b0;
    end
    else if (!enable)
    begin
      gap_ff  <= `CSRF_CNT_W'(`CSRF_FILTER_CYC);
      good_ff <= '0;
      last_ff <= osc_level;
    end
    else if (!freeze)
    begin
      last_ff <= osc_level;
      if (edge_seen)
        gap_ff <= '0;
      else if (gap_ff != '1)
        gap_ff <= gap_ff + 8'h01;
      // any spike restarts the good run
      if (too_fast || (gap_ff >= `CSRF_CNT_W'(`CSRF_BACKUP_CYC)))
        good_ff <= '0;
      else if (edge_seen && good_ff != '1)
        good_ff <= good_ff + 8'h01;
    end
  end

  // filter blocks spikes, backup takes over after a silent period
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      filtered_ff <= 1'b0;
      backup_ff   <= 1'b0;
    end
    else if (!enable)
    begin
      filtered_ff <= 1'b0;
      backup_ff   <= 1'b0;
    end
    else if (!freeze)
    begin
      if (too_fast)
        filtered_ff <= 1'b1;
      else if (recovered)
        filtered_ff <= 1'b0;
      if (gap_ff >= `CSRF_CNT_W'(`CSRF_BACKUP_CYC - 1) && !edge_seen)
        backup_ff <= 1'b1;
      else if (recovered)
        backup_ff <= 1'b0;
    end
  end

endmodule

// [verilog/csrf_pkg.sv]
// Purpose: types shared by the clock security and reset flag block
// Assumes: constants live in csrf_regs.svh
// Notes:   none
`include "csrf_regs.svh"
package csrf_pkg;

  // register port request
  typedef struct packed {
    logic [`CSRF_ADDR_W-1:0] addr;
    logic [7:0]              wdata;
    logic                    wr;
    logic                    rd;
  } csrf_req_s;

  // main clock source option
  typedef enum logic [2:0] {
    CSRF_SRC_EXT   = 3'h0,
    CSRF_SRC_XTAL0 = 3'h1,
    CSRF_SRC_XTAL1 = 3'h2,
    CSRF_SRC_XTAL2 = 3'h3,
    CSRF_SRC_XTAL3 = 3'h4,
    CSRF_SRC_EXTRC = 3'h5,
    CSRF_SRC_INTRC = 3'h6
  } csrf_osc_src_e;

  // reset pin driver states
  typedef enum logic [2:0] {
    CSRF_PIN_IDLE   = 3'h1,
    CSRF_PIN_SUPPLY = 3'h2,
    CSRF_PIN_WDG    = 3'h4
  } csrf_pin_st_e;

endpackage

// [verilog/csrf_regs.svh]
// Purpose: constants for the clock security and reset flag block
// Assumes: ref_clk at 10 MHz
// Notes:   times are in ns, cycle counts derive from them
`ifndef CSRF_REGS_SVH
`define CSRF_REGS_SVH

// register map
`define CSRF_ADDR_W          16
`define CSRF_STATUS_ADDR     16'h002B
`define CSRF_STATUS_RESET    8'h00
`define CSRF_READ_UNMAPPED   8'h00

// field positions in reset_clock_status
`define CSRF_BIT_WDG_FLAG    0
`define CSRF_BIT_DETECTED    1
`define CSRF_BIT_IRQ_EN      2
`define CSRF_BIT_SUPPLY_FLAG 4

// shared interrupt vector slot and address pair
`define CSRF_IRQ_SLOT        4'h1
`define CSRF_IRQ_VECTOR      16'hFFF8

// timing
`define CSRF_CLK_PERIOD_NS   100
`define CSRF_RST_PULSE_NS    20000
`define CSRF_BACKUP_NS       4000
`define CSRF_FILTER_NS       300
`define CSRF_RECOVER_EDGES   8'h04
`define CSRF_CNT_W           8

// least times round up to whole cycles
`define CSRF_RST_PULSE_CYC \
  ((`CSRF_RST_PULSE_NS + `CSRF_CLK_PERIOD_NS - 1) / `CSRF_CLK_PERIOD_NS)
`define CSRF_BACKUP_CYC \
  ((`CSRF_BACKUP_NS + `CSRF_CLK_PERIOD_NS - 1) / `CSRF_CLK_PERIOD_NS)
`define CSRF_FILTER_CYC \
  ((`CSRF_FILTER_NS + `CSRF_CLK_PERIOD_NS - 1) / `CSRF_CLK_PERIOD_NS)

`endif

// [verilog/csrf_sync.sv]
// Purpose: two flip-flop synchroniser for asynchronous levels
// Assumes: inputs are slow levels relative to ref_clk
// Notes:   only the second stage leaves this module
`timescale 1ns/100ps
module csrf_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst,
  // levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_ff;

  // first stage feeds the second stage only
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      meta_ff  <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end

endmodule

// [verilog/csrf_top.sv]
// Purpose: clock security unit, reset pin driver and reset_clock_status
// Assumes: option inputs are static; cpu side signals share ref_clk
// Notes:   rst is the power-on reset; pin and watchdog resets are events
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/100ps
module csrf_top (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // register port
  input  csrf_pkg::csrf_req_s    bus_req,
  output logic [7:0]             rd_data_ff,
  // option settings
  input  wire logic              css_enable_opt,
  input  csrf_pkg::csrf_osc_src_e osc_src_opt,
  // pins
  input  wire logic              osc_in_pin,
  input  wire logic              supply_low,
  input  wire logic              rst_pin_in_n,
  output logic                   rst_pin_out_ff,
  output logic                   rst_pin_oe_ff,
  // cpu side
  input  wire logic              wdg_underflow,
  input  wire logic              cpu_irq_mask,
  input  wire logic              wait_mode,
  input  wire logic              halt_mode,
  output logic                   css_irq_ff,
  output logic                   wake_req_ff,
  // clock control
  output logic                   backup_sel_ff,
  output logic                   clk_filtered_ff,
  output logic                   osc_keep_run_ff,
  output logic                   osc_enable_ff
);
  import csrf_pkg::*;
  `include "csrf_regs.svh"

  logic [2:0]             sync_q;
  logic                   osc_s;
  logic                   supply_low_s;
  logic                   pin_low_s;
  logic                   supply_last_ff;
  logic                   supply_evt;
  logic                   pin_evt;
  logic                   pin_last_ff;
  logic                   opt_taken_ff;
  logic                   css_en_ff;
  csrf_osc_src_e          src_ff;
  logic                   is_xtal;
  csrf_pin_st_e           pin_st_ff;
  csrf_pin_st_e           nxt_pin_st;
  logic [`CSRF_CNT_W-1:0] pulse_ff;
  logic                   supply_flag_ff;
  logic                   wdg_flag_ff;
  logic                   irq_en_ff;
  logic                   det_ff;
  logic                   mon_backup;
  logic                   mon_filtered;
  logic                   hit;
  logic                   wr_hit;
  logic                   rd_hit;
  logic                   nxt_irq;
  logic [7:0]             status;

  // pins cross into ref_clk before any logic looks at them
  csrf_sync #(.W(3)) u_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in ({osc_in_pin, supply_low, ~rst_pin_in_n}),
    .sync_out (sync_q)
  );
  assign osc_s        = sync_q[2];
  assign supply_low_s = sync_q[1];
  assign pin_low_s    = sync_q[0];

  // option caught once, after reset release
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      opt_taken_ff <= 1'b0;
      css_en_ff    <= 1'b0;
      src_ff       <= CSRF_SRC_EXT;
    end
    else if (!opt_taken_ff)
    begin
      opt_taken_ff <= 1'b1;
      css_en_ff    <= css_enable_opt;
      src_ff       <= osc_src_opt;
    end
  end

  // crystal ranges are the four middle codes
  assign is_xtal = (src_ff == CSRF_SRC_XTAL0) ||
                   (src_ff == CSRF_SRC_XTAL1) ||
                   (src_ff == CSRF_SRC_XTAL2) ||
                   (src_ff == CSRF_SRC_XTAL3);

  // filter and backup selection, gated by option and halt
  csrf_clk_mon u_mon (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .enable      (css_en_ff),
    .freeze      (halt_mode),
    .osc_level   (osc_s),
    .backup_ff   (mon_backup),
    .filtered_ff (mon_filtered)
  );

  // rising edges of the reset causes
  assign supply_evt = supply_low_s & ~supply_last_ff;
  assign pin_evt    = pin_low_s & ~pin_last_ff & ~rst_pin_oe_ff;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      supply_last_ff <= 1'b0;
      pin_last_ff    <= 1'b0;
    end
    else
    begin
      supply_last_ff <= supply_low_s;
      pin_last_ff    <= pin_low_s;
    end
  end

  // reset pin driver: supply low outranks a watchdog pulse
  always_comb
  begin
    nxt_pin_st = pin_st_ff;
    case (pin_st_ff)
      CSRF_PIN_IDLE:
        if (supply_low_s)
          nxt_pin_st = CSRF_PIN_SUPPLY;
        else if (wdg_underflow)
          nxt_pin_st = CSRF_PIN_WDG;
      CSRF_PIN_SUPPLY:
        if (!supply_low_s)
          nxt_pin_st = CSRF_PIN_IDLE;
      CSRF_PIN_WDG:
        if (supply_low_s)
          nxt_pin_st = CSRF_PIN_SUPPLY;
        else if (pulse_ff >= `CSRF_CNT_W'(`CSRF_RST_PULSE_CYC - 1))
          nxt_pin_st = CSRF_PIN_IDLE;
      default:
        nxt_pin_st = CSRF_PIN_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      pin_st_ff      <= CSRF_PIN_IDLE;
      rst_pin_oe_ff  <= 1'b0;
      rst_pin_out_ff <= 1'b0;
    end
    else
    begin
      pin_st_ff      <= nxt_pin_st;
      rst_pin_oe_ff  <= (nxt_pin_st != CSRF_PIN_IDLE);
      rst_pin_out_ff <= 1'b0; // open drain, only ever pulls low
    end
  end

  // cycles spent in the watchdog pulse
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      pulse_ff <= '0;
    else if (pin_st_ff == CSRF_PIN_WDG && pulse_ff != '1)
      pulse_ff <= pulse_ff + 8'h01;
    else if (pin_st_ff != CSRF_PIN_WDG)
      pulse_ff <= '0;
  end

  // crystal runs through reset; halt stops the others
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      osc_keep_run_ff <= 1'b0;
      osc_enable_ff   <= 1'b0;
    end
    else
    begin
      osc_keep_run_ff <= is_xtal;
      osc_enable_ff   <= is_xtal | (~halt_mode & ~rst_pin_oe_ff);
    end
  end

  // register decode; halt blocks writes and the read clear, not read data
  assign hit    = (bus_req.addr == `CSRF_STATUS_ADDR);
  assign wr_hit = hit & bus_req.wr & ~halt_mode;
  assign rd_hit = hit & bus_req.rd & ~halt_mode;

  // supply flag; pin and watchdog leave it alone
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      supply_flag_ff <= 1'b0;
    else if (supply_evt)
      supply_flag_ff <= 1'b1; // set wins over a write of zero
    else if (wr_hit && !bus_req.wdata[`CSRF_BIT_SUPPLY_FLAG])
      supply_flag_ff <= 1'b0;
  end

  // watchdog flag, cleared also by a supply reset
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      wdg_flag_ff <= 1'b0;
    else if (supply_evt || pin_evt)
      wdg_flag_ff <= 1'b0; // pin reset clears this bit and keeps the supply bit
    else if (wdg_underflow)
      wdg_flag_ff <= 1'b1;
    else if (wr_hit && !bus_req.wdata[`CSRF_BIT_WDG_FLAG])
      wdg_flag_ff <= 1'b0;
  end

  // any reset event restarts the enable from zero
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      irq_en_ff <= 1'b0;
    else if (supply_evt || pin_evt || wdg_underflow)
      irq_en_ff <= 1'b0;
    else if (wr_hit)
      irq_en_ff <= bus_req.wdata[`CSRF_BIT_IRQ_EN];
  end

  // detection flag follows backup, read clears once recovered
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      det_ff <= 1'b0;
    else if (!css_en_ff || supply_evt || pin_evt || wdg_underflow)
      det_ff <= 1'b0;
    else if (halt_mode)
      det_ff <= det_ff; // frozen while halted
    // read during backup keeps the flag
    else if (mon_backup)
      det_ff <= 1'b1;
    else if (rd_hit)
      det_ff <= 1'b0;
  end

  // detection reads zero when the unit is off
  assign status = {3'h0, supply_flag_ff, 1'b0, irq_en_ff,
                   det_ff & css_en_ff, wdg_flag_ff};

  // read data stand only in the cycle after the strobe
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      rd_data_ff <= `CSRF_STATUS_RESET;
    else if (bus_req.rd && hit)
      rd_data_ff <= status;
    else
      rd_data_ff <= `CSRF_READ_UNMAPPED;
  end

  // request needs enable and a clear cpu mask
  // request feeds the shared slot-1 vector
  assign nxt_irq = css_en_ff & irq_en_ff & det_ff & ~cpu_irq_mask;

  // wait mode keeps everything running and the request wakes it
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      css_irq_ff  <= 1'b0;
      wake_req_ff <= 1'b0;
    end
    else
    begin
      css_irq_ff  <= nxt_irq;
      wake_req_ff <= nxt_irq & wait_mode;
    end
  end

  // backup selection and filter state to the clock tree
  // both drop without software when the source recovers
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      backup_sel_ff   <= 1'b0;
      clk_filtered_ff <= 1'b0;
    end
    else
    begin
      backup_sel_ff   <= mon_backup & ~halt_mode;
      clk_filtered_ff <= mon_filtered;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  AST_SUPPLY_PIN: assert property (
    supply_low_s |=> rst_pin_oe_ff)
    else $error("reset pin not driven during low supply");

  AST_WDG_PULSE: assert property (
    (pin_st_ff == CSRF_PIN_IDLE && wdg_underflow && !supply_low_s)
      |=> rst_pin_oe_ff [*8])
    else $error("watchdog reset pulse too short");

  AST_XTAL_RUN: assert property (
    is_xtal && osc_keep_run_ff |=> osc_enable_ff)
    else $error("crystal stopped during reset");

  AST_CSS_OFF: assert property (
    !css_en_ff && bus_req.rd && hit
      |=> !rd_data_ff[`CSRF_BIT_DETECTED] && !css_irq_ff)
    else $error("detection visible while unit disabled");

  AST_IRQ_GATE: assert property (
    css_irq_ff |-> $past(irq_en_ff) && !$past(cpu_irq_mask))
    else $error("interrupt without enable or with mask set");

  AST_DET_SET: assert property (
    mon_backup && css_en_ff && !halt_mode && !supply_evt
      && !pin_evt && !wdg_underflow |=> det_ff)
    else $error("detection flag missed backup selection");

  AST_READ_KEEP: assert property (
    det_ff && rd_hit && mon_backup && !supply_evt && !pin_evt
      && !wdg_underflow |=> det_ff)
    else $error("read cleared flag during backup");

  AST_SUPPLY_CLR: assert property (
    supply_evt |=> !wdg_flag_ff && supply_flag_ff)
    else $error("supply reset flags wrong");

  AST_HALT_FREEZE: assert property (
    halt_mode && css_en_ff && !supply_evt && !pin_evt && !wdg_underflow
      |=> $stable(det_ff) && $stable(irq_en_ff))
    else $error("status changed during halt");

  AST_WAIT_WAKE: assert property (
    nxt_irq && wait_mode |=> wake_req_ff && css_irq_ff)
    else $error("interrupt did not wake from wait");

endmodule
